// ### bcx_decode.sv
// Opcode decoder: classifies the instruction and resolves the data address
`timescale 1ns/100ps
module bcx_decode
(
	input wire logic [15:0] opcode_in,
	input wire logic ext_set_in,
	input wire logic [3:0] bank_sel_in,
	input wire logic [7:0] fsr2_base_in,
	output bcx_pkg::bcx_kind_e kind_out,
	output logic [11:0] addr_out,
	output logic indexed_out
);
	// Classify by the upper opcode bits
	always_comb
	begin
		kind_out = bcx_pkg::BCX_KIND_NONE;
		if (opcode_in[15:12] == bcx_pkg::OP_BIT_CLEAR)
			kind_out = bcx_pkg::BCX_KIND_BCLR;
		else if (opcode_in[15:10] == bcx_pkg::OP_INC_SKIP_ZERO)
			kind_out = bcx_pkg::BCX_KIND_INCZ;
		else if (opcode_in[15:10] == bcx_pkg::OP_INC_SKIP_NONZERO)
			kind_out = bcx_pkg::BCX_KIND_INCNZ;
		else if (opcode_in[15:8] == bcx_pkg::OP_BRANCH_NEG)
			kind_out = bcx_pkg::BCX_KIND_BRN;
	end

	// Address: access bank, indexed offset, or banked; indexed wins when enabled
	always_comb
	begin
		indexed_out = ext_set_in && !opcode_in[bcx_pkg::POS_ACCESS]
			&& (opcode_in[7:0] <= bcx_pkg::IDX_LIMIT);
		if (indexed_out)
			addr_out = {4'h0, fsr2_base_in} + {4'h0, opcode_in[7:0]};
		else if (!opcode_in[bcx_pkg::POS_ACCESS])
			addr_out = {{4{opcode_in[7]}}, opcode_in[7:0]};
		else
			addr_out = {bank_sel_in, opcode_in[7:0]};
	end
endmodule : bcx_decode

// ### bcx_exec.sv
// Execution unit for bit clear, increment-with-skip and branch on negative
//
// How it works
// - Bit-clear opcode forces chosen file bit to zero; flags untouched.
// - Bank bit 0 means access bank; 1 means bank select register bank.
// - Extended set, bank bit 0, address up to 95: indexed literal offset.
// - Increment-skip-zero opcode adds one to the file value; flags untouched.
// - Destination 0 writes working register; 1 writes file register.
// - Zero result discards fetched next instruction; one no-operation cycle added.
// - Discarded two-word instruction adds two no-operation cycles, three total.
// - Increment-skip-nonzero skips the next instruction when result nonzero.
`timescale 1ns/100ps
module bcx_exec
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic phase_ena_in,
	input wire logic instr_valid_in,
	input wire logic [15:0] opcode_in,
	input wire logic next_two_word_in,
	input wire logic ext_set_in,
	input wire logic [3:0] bank_sel_in,
	input wire logic [7:0] fsr2_base_in,
	input wire logic [7:0] file_rdata_in,
	input wire logic negative_in,
	input wire logic [20:0] pc_in,
	output logic busy_out,
	output logic [11:0] file_addr_out,
	output logic file_we_out,
	output logic [7:0] file_wdata_out,
	output logic wreg_we_out,
	output logic [7:0] wreg_wdata_out,
	output logic pc_load_out,
	output logic [20:0] pc_value_out,
	output logic no_operation_out
);
	////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [1:0] phase;
		logic [1:0] nop_left;
		bcx_pkg::bcx_kind_e kind;
		logic [15:0] op;
		logic [11:0] addr;
		logic file_we;
		logic [7:0] file_wdata;
		logic wreg_we;
		logic [7:0] wreg_wdata;
		logic pc_load;
		logic [20:0] pc_value;
		logic nop_out;
	} bcx_state_s;

	// One struct holds all state, so reset clears every field alike; hold keeps all but the three strobes
	bcx_state_s st_q;
	bcx_state_s st_d;
	bcx_pkg::bcx_kind_e dec_kind;
	logic [11:0] dec_addr;

	////////////////////////////////////////////////////////////////////////////
	// Decoder
	bcx_decode u_decode
	(
		.opcode_in(opcode_in),
		.ext_set_in(ext_set_in),
		.bank_sel_in(bank_sel_in),
		.fsr2_base_in(fsr2_base_in),
		.kind_out(dec_kind),
		.addr_out(dec_addr),
		.indexed_out() // Address is already resolved; the mode flag is not needed here
	);

	////////////////////////////////////////////////////////////////////////////
	// Package sanity: counts and field positions must suit the widths used below
	// A bad constant stops elaboration rather than giving quietly wrong results
	generate
		// Phase counter is two bits wide, so a cycle must be exactly four phases
		if (bcx_pkg::LAST_PHASE != 2'h3)
		begin : g_bad_phase
			$error("phase count does not fit the two-bit phase counter");
		end
		// Bit index is three bits and must lie inside the opcode word
		if (bcx_pkg::POS_BIT_LO + 3 > 16)
		begin : g_bad_bit_field
			$error("bit index field lies outside the opcode word");
		end
		// Destination and access bits must lie inside the opcode word
		if (bcx_pkg::POS_DEST > 15 || bcx_pkg::POS_ACCESS > 15)
		begin : g_bad_flag_bits
			$error("operand bit position lies outside the opcode word");
		end
		// Two-bit slot counter; a two-word skip owes more slots than a one-word one
		if (bcx_pkg::NOP_TWO_WORD <= bcx_pkg::NOP_ONE_WORD || bcx_pkg::NOP_ONE_WORD == 2'h0)
		begin : g_bad_skip_count
			$error("skip slot counts are inconsistent");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Next state, one step per phase enable:
	//   phase 0 latches opcode and resolved address, or runs an owed idle slot
	//   phases 1 and 2 only advance the counter while the file read settles
	//   phase 3 computes the result and raises the write or branch strobe
	// Strobes land on the clock after the phase 3 enable and last one clock.
	// Hazard: file read data is only looked at on the phase 3 enable and is
	// not latched earlier, so a slow file path gives a wrong result, not a stall.
	// Idle slots are counted in whole instruction cycles, so an owed idle
	// cycle keeps its length in phases whatever the enable rate is.
	// Opcodes offered while slots are owed are ignored, not queued.
	logic [7:0] inc_val;
	logic skip;
	logic [2:0] bitn;
	logic [20:0] branch_off;
	always_comb
	begin
		st_d = st_q;
		inc_val = file_rdata_in + 8'h01;
		skip = 1'b0;
		bitn = st_q.op[bcx_pkg::POS_BIT_LO +: 3];
		branch_off = {{12{st_q.op[7]}}, st_q.op[7:0], 1'b0};
		// Write strobes are one-cycle pulses
		st_d.file_we = 1'b0;
		st_d.wreg_we = 1'b0;
		st_d.pc_load = 1'b0;
		if (phase_ena_in)
		begin
			st_d.phase = st_q.phase + 2'h1;
			case (st_q.phase)
				2'h0:
				begin
					// Slots owed to a discarded instruction run as no-operations
					if (st_q.nop_left != 2'h0)
					begin
						st_d.nop_left = st_q.nop_left - 2'h1;
						st_d.nop_out = 1'b1;
						st_d.kind = bcx_pkg::BCX_KIND_NONE;
					end
					else
					begin
						st_d.nop_out = 1'b0;
						st_d.kind = instr_valid_in ? dec_kind : bcx_pkg::BCX_KIND_NONE;
						st_d.op = opcode_in;
						st_d.addr = dec_addr;
					end
				end
				bcx_pkg::LAST_PHASE:
				begin
					case (st_q.kind)
						bcx_pkg::BCX_KIND_BCLR:
						begin
							// Only the chosen bit changes; no flag update path exists
							st_d.file_we = 1'b1;
							st_d.file_wdata = file_rdata_in & ~(8'h01 << bitn);
						end
						bcx_pkg::BCX_KIND_INCZ, bcx_pkg::BCX_KIND_INCNZ:
						begin
							if (st_q.op[bcx_pkg::POS_DEST])
							begin
								st_d.file_we = 1'b1;
								st_d.file_wdata = inc_val;
							end
							else
							begin
								st_d.wreg_we = 1'b1;
								st_d.wreg_wdata = inc_val;
							end
							if (st_q.kind == bcx_pkg::BCX_KIND_INCZ)
								skip = (inc_val == 8'h00);
							else
								skip = (inc_val != 8'h00);
							if (skip)
								st_d.nop_left = next_two_word_in ? bcx_pkg::NOP_TWO_WORD
									: bcx_pkg::NOP_ONE_WORD;
						end
						bcx_pkg::BCX_KIND_BRN:
						begin
							// PC already points past this word, so add only 2n
							if (negative_in)
							begin
								st_d.pc_load = 1'b1;
								st_d.pc_value = pc_in + branch_off;
								st_d.nop_left = bcx_pkg::NOP_ONE_WORD;
							end
						end
						default:
						begin
							st_d.pc_load = 1'b0;
						end
					endcase
				end
				default:
				begin
					st_d.phase = st_q.phase + 2'h1;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	// All come straight from the state register, so no input reaches an output
	assign busy_out = (st_q.nop_left != 2'h0);
	assign file_addr_out = st_q.addr;
	assign file_we_out = st_q.file_we;
	assign file_wdata_out = st_q.file_wdata;
	assign wreg_we_out = st_q.wreg_we;
	assign wreg_wdata_out = st_q.wreg_wdata;
	assign pc_load_out = st_q.pc_load;
	assign pc_value_out = st_q.pc_value;
	assign no_operation_out = st_q.nop_out;
endmodule : bcx_exec

// ### bcx_exec_assertions.sv
// Concurrent checks on the execution unit ports
`timescale 1ns/100ps
module bcx_chk
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic negative_in,
	input wire logic busy_out,
	input wire logic file_we_out,
	input wire logic wreg_we_out,
	input wire logic pc_load_out,
	input wire logic no_operation_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);
	////////////////////////////////////////
	// Strobes last one clock and one destination takes each result
	one_dest_a: assert property (!(file_we_out && wreg_we_out))
		else $error("file and working writes together");
	file_pulse_a: assert property (file_we_out |=> !file_we_out)
		else $error("file write longer than a clock");
	wreg_pulse_a: assert property (wreg_we_out |=> !wreg_we_out)
		else $error("working write longer than a clock");
	// A taken branch writes no data and costs an extra cycle
	pcl_pulse_a: assert property (pc_load_out |=> !pc_load_out)
		else $error("pc load longer than a clock");
	pcl_quiet_a: assert property (pc_load_out |-> !file_we_out && !wreg_we_out)
		else $error("branch wrote data");
	pcl_neg_a: assert property (pc_load_out |-> $past(negative_in))
		else $error("branch taken with flag clear");
	pcl_nop_a: assert property (pc_load_out |-> ##[0:16] no_operation_out)
		else $error("taken branch without idle cycle");
	// An inserted idle cycle spans all four phases, so at least four clocks
	nop_hold_a: assert property ($rose(no_operation_out) |-> no_operation_out[*4])
		else $error("idle cycle too short");
	// An idle cycle only starts when a slot was owed
	nop_owed_a: assert property ($rose(no_operation_out) |-> $past(busy_out))
		else $error("idle cycle with nothing owed");
	cover property ($rose(no_operation_out));
	cover property (file_we_out);
	cover property (pc_load_out);
endmodule : bcx_chk
bind bcx_exec bcx_chk i_chk (.*);

// ### bcx_pkg.sv
// Package of opcode patterns, field positions and cycle counts for the bit/increment/branch unit
package bcx_pkg;
	// Opcode pattern fields
	localparam logic [3:0] OP_BIT_CLEAR = 4'h9;
	localparam logic [5:0] OP_INC_SKIP_ZERO = 6'h0F;
	localparam logic [5:0] OP_INC_SKIP_NONZERO = 6'h12;
	localparam logic [7:0] OP_BRANCH_NEG = 8'hE6;
	// Field positions within the 16-bit opcode
	localparam int POS_BIT_LO = 9;
	localparam int POS_ACCESS = 8;
	localparam int POS_DEST = 9;
	// Indexed literal offset limit (file address at or below this)
	localparam logic [7:0] IDX_LIMIT = 8'h5F;
	// Number of no-operation cycles inserted for a discarded one- or two-word instruction
	localparam logic [1:0] NOP_ONE_WORD = 2'h1;
	localparam logic [1:0] NOP_TWO_WORD = 2'h2;
	// Index of the last quarter phase per instruction cycle
	localparam logic [1:0] LAST_PHASE = 2'h3;
	// Instruction kinds
	typedef enum logic [2:0] {
		BCX_KIND_NONE,
		BCX_KIND_BCLR,
		BCX_KIND_INCZ,
		BCX_KIND_INCNZ,
		BCX_KIND_BRN
	} bcx_kind_e;
endpackage : bcx_pkg

// ### testbench.sv
// Random and corner-case bench for the execution unit
`timescale 1ns/100ps
module testbench;
	logic ref_clk_in = 1'h0, resetn_in = 1'h0, phase_ena_in = 1'h1, instr_valid_in = 1'h0;
	logic next_two_word_in = 1'h0, ext_set_in = 1'h0, negative_in = 1'h0;
	logic [15:0] opcode_in = 16'h0000;
	logic [3:0] bank_sel_in = 4'h0;
	logic [7:0] fsr2_base_in = 8'h00, file_rdata_in = 8'h00, wreg_wdata_out, file_wdata_out;
	logic [20:0] pc_in = 21'h0_0000, pc_value_out;
	logic [11:0] file_addr_out;
	logic busy_out, file_we_out, wreg_we_out, pc_load_out, no_operation_out;
	int mismatches = 0, n_tests = 0, cyc = 0;
	bcx_exec i_dut (.*);
	////////////////////////////////////////
	// Clock and a ceiling that cuts a hang short
	initial forever #10 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			mismatches++;
			end_sim();
		end
	end
	task chk(input string nm, input logic [20:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	// Data address: bank register, indexed window, or sign-extended access bank
	function automatic logic [11:0] xaddr(input logic [15:0] op);
		if (op[8]) return {bank_sel_in, op[7:0]};
		if (ext_set_in && op[7:0] <= 8'h5F) return {4'h0, fsr2_base_in} + {4'h0, op[7:0]};
		return {{4{op[7]}}, op[7:0]};
	endfunction : xaddr
	// One instruction, then three spare cycles; dv clocks per phase enable
	task automatic run(input logic [15:0] op, input logic [7:0] rd, input logic neg, two,
		input int dv);
		logic [7:0] r = rd + 8'h01, fd, wd;
		logic [11:0] fa;
		logic [20:0] pv = 21'h0_0000;
		logic fw = 1'h0, ww = 1'h0, pl = 1'h0, bc, br, ef, sk;
		int nn = 0, nb = 0;
		opcode_in = op;
		file_rdata_in = rd;
		negative_in = neg;
		next_two_word_in = two;
		instr_valid_in = 1'h1;
		phase_ena_in = 1'h1;
		for (int i = 0; i < 16 * dv; i++)
		begin
			@(negedge ref_clk_in);
			instr_valid_in = (i < 3);
			phase_ena_in = ((i + 1) % dv == 0);
			fw |= file_we_out;
			ww |= wreg_we_out;
			pl |= pc_load_out;
			nn += (no_operation_out === 1'h1);
			nb += (busy_out === 1'h1);
			if (file_we_out === 1'h1) fd = file_wdata_out;
			if (wreg_we_out === 1'h1) wd = wreg_wdata_out;
			if (pc_load_out === 1'h1) pv = pc_value_out;
			if ((file_we_out | wreg_we_out) === 1'h1) fa = file_addr_out;
		end
		bc = op[15:12] == bcx_pkg::OP_BIT_CLEAR;
		br = op[15:8] == bcx_pkg::OP_BRANCH_NEG;
		ef = !br && (bc || op[9]);
		sk = br ? neg : !bc && ((op[15:10] == bcx_pkg::OP_INC_SKIP_ZERO) == (r == 8'h00));
		chk("strobes", 21'({fw, ww, pl}), 21'({ef, !br && !ef, br && neg}));
		chk("idle", 21'(nn), 21'(sk ? (two && !br ? 8 : 4) * dv : 0));
		chk("busy", 21'(nb != 0), 21'(sk));
		if (br) chk("pc", pv, neg ? pc_in + {{12{op[7]}}, op[7:0], 1'h0} : 21'h0_0000);
		else if (bc) chk("clear", 21'(fd), 21'(rd & ~(8'h01 << op[11:9])));
		else chk("inc", 21'(ef ? fd : wd), 21'(r));
		if (!br) chk("addr", 21'(fa), 21'(xaddr(op)));
	endtask : run
	////////////////////////////////////////
	// Four kinds in turn, with wrap-to-zero data and indexed-limit addresses mixed in;
	// the last third runs at half the phase enable rate
	initial
	begin
		logic [15:0] op;
		void'($urandom(32'h8442_1f4b));
		repeat (3) @(negedge ref_clk_in);
		resetn_in = 1'h1;
		for (int t = 0; t < 48; t++)
		begin
			op = 16'($urandom);
			ext_set_in = 1'($urandom);
			bank_sel_in = 4'($urandom);
			fsr2_base_in = 8'($urandom);
			pc_in = 21'($urandom);
			if (t % 3 == 0) op[7:0] = (t % 2) ? 8'h5F : 8'h60;
			if (t % 4 == 0) op[15:12] = bcx_pkg::OP_BIT_CLEAR;
			else if (t % 4 == 3) op[15:8] = bcx_pkg::OP_BRANCH_NEG;
			else op[15:10] = (t % 4 == 1) ? bcx_pkg::OP_INC_SKIP_ZERO : bcx_pkg::OP_INC_SKIP_NONZERO;
			run(op, (t % 3 == 1) ? 8'hFF : 8'($urandom), 1'($urandom), 1'($urandom),
				(t < 32) ? 1 : 2);
		end
		// Reset while a two-word skip is owed: idle slots and strobes drop at once
		opcode_in = {bcx_pkg::OP_INC_SKIP_ZERO, 10'h310};
		file_rdata_in = 8'hFF;
		next_two_word_in = 1'h1;
		instr_valid_in = 1'h1;
		phase_ena_in = 1'h1;
		repeat (5) @(negedge ref_clk_in);
		instr_valid_in = 1'h0;
		chk("owed", 21'({busy_out, no_operation_out}), 21'h3);
		resetn_in = 1'h0;
		@(negedge ref_clk_in);
		chk("reset", 21'({busy_out, no_operation_out, file_we_out, pc_load_out}), 21'h0);
		resetn_in = 1'h1;
		// First instruction straight after release: nonzero result skips a two-word slot
		run({bcx_pkg::OP_INC_SKIP_NONZERO, 10'h05F}, 8'h7F, 1'h0, 1'h1, 1);
		end_sim();
	end
endmodule : testbench
